// ==== smb_pkg.sv ====
// Constants and state type of the two-wire bus controller
package smb_pkg;
  // System clock and SCL-low timeout, derived to cycles
  localparam int SYS_CLK_HZ = 20_000_000;
  localparam int LOW_TIMEOUT_MS = 25;
  localparam int LOW_TIMEOUT_CYC = SYS_CLK_HZ / 1000 * LOW_TIMEOUT_MS;
  // Bus-free timeout: more than ten source periods
  localparam logic [3:0] FREE_TICKS = 4'hb;
  localparam logic [3:0] FREE_CNT_MAX = 4'hf;
  // Master phase minimums in source overflow ticks
  localparam logic [1:0] LOW_TICKS = 2'h1;
  localparam logic [1:0] HIGH_TICKS = 2'h2;
  localparam logic [1:0] PHASE_CNT_MAX = 2'h3;
  // Bit positions within a byte transfer
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [7:0] DATA_RST = 8'h00;
  // Controller states
  typedef enum logic [3:0] {
    SMB_IDLE,
    SMB_START_A,
    SMB_START_B,
    SMB_START_C,
    SMB_LOW,
    SMB_HIGH,
    SMB_WAIT,
    SMB_STOP_A,
    SMB_STOP_B,
    SMB_STOP_C
  } smb_state_t;
endpackage : smb_pkg

// ==== smb_sync.sv ====
// Two-stage synchroniser with synchronous reset and clock enable
`timescale 1ns/10ps
`default_nettype none
module smb_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  // First stage feeds only the second
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      meta_reg <= RST_VAL;
      q <= RST_VAL;
    end
    else if (clk_en)
    begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule : smb_sync
`default_nettype wire

// ==== smb_tick_cnt.sv ====
// Saturating tick counter with synchronous clear
`timescale 1ns/10ps
`default_nettype none
module smb_tick_cnt #(
  parameter int W = 4,
  parameter logic [W-1:0] MAX = '1
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic clear,
  input wire logic tick,
  output logic [W-1:0] count
);
  if (W < 1 || W > 24)
  begin : g_chk
    $error("smb_tick_cnt: width out of range");
  end

  // Count ticks, hold at the ceiling
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      count <= '0;
    else if (clk_en)
    begin
      if (clear)
        count <= '0;
      else if (tick && count != MAX)
        count <= count + 1'b1;
    end
  end
endmodule : smb_tick_cnt
`default_nettype wire

// ==== smb_iface.sv ====
// Byte-oriented two-wire bus controller, master and slave
`timescale 1ns/10ps
`default_nettype none
module smb_iface #(
  parameter int LOW_TIMEOUT_CYC = smb_pkg::LOW_TIMEOUT_CYC
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic link_clk,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic enable_iface,
  input wire logic low_timeout_enable,
  input wire logic free_timeout_enable,
  input wire logic [1:0] src_sel,
  input wire logic [3:0] src_ovf,
  input wire logic sw_start,
  input wire logic sw_stop,
  input wire logic sw_go,
  input wire logic sw_ack_send,
  input wire logic sw_data_load,
  input wire logic [7:0] sw_data,
  output logic [7:0] shift_data,
  output logic byte_irq,
  output logic start_sent,
  output logic stop_seen,
  output logic arb_lost,
  output logic ack_received,
  output logic is_master,
  output logic is_tx,
  output logic bus_busy,
  output logic low_timeout,
  output logic timer_reload
);
  localparam int LTW = $clog2(LOW_TIMEOUT_CYC + 1);
  localparam logic [LTW-1:0] LT_MAX = LTW'(LOW_TIMEOUT_CYC);

  if (LOW_TIMEOUT_CYC < 2 || LTW > 24)
  begin : g_chk
    $error("smb_iface: low timeout count out of range");
  end

  smb_pkg::smb_state_t state_reg, state_next;
  logic [3:0] bit_cnt_reg, bit_next;
  logic [7:0] shift_data_reg, shd_next;
  logic master_reg, master_next, tx_reg, tx_next, addr_reg, addr_next;
  logic rw_reg, rw_next, ack_send_reg, ack_send_next;
  logic ack_rx_reg, ack_rx_next, stop_pend_reg, stop_pend_next;
  logic start_pend_reg, start_pend_next, busy_reg, busy_next;
  logic si_reg, start_reg, stop_reg, arb_reg, lto_reg;
  logic si_set, start_set, stop_set, arb_set;
  logic scl_drv_reg, scl_drv_next, sda_drv_reg, sda_drv_next;
  logic scl_d_reg, sda_d_reg, reload_reg, link_rst;
  logic scl_s, sda_s, scl_lk, sda_lk, scl_drv_lk, sda_drv_lk;
  logic [1:0] ph_cnt;
  logic [3:0] free_cnt;
  logic [LTW-1:0] lt_cnt;

  // Link-side reset, pin sampling and open-drain drive on link clock, then pins resampled on system clock
  smb_sync #(.W(1), .RST_VAL(1'b1)) u_rst_link (
    .clock(link_clk), .rst(1'b0), .clk_en(1'b1),
    .d(sys_rst), .q(link_rst));
  smb_sync #(.W(2), .RST_VAL(2'h3)) u_pin_link (
    .clock(link_clk), .rst(link_rst), .clk_en(1'b1),
    .d({scl_in, sda_in}), .q({scl_lk, sda_lk}));
  smb_sync #(.W(2), .RST_VAL(2'h0)) u_drv_link (
    .clock(link_clk), .rst(link_rst), .clk_en(1'b1),
    .d({scl_drv_reg, sda_drv_reg}), .q({scl_drv_lk, sda_drv_lk}));
  smb_sync #(.W(2), .RST_VAL(2'h3)) u_pin_sys (
    .clock(clock), .rst(sys_rst), .clk_en(clk_en),
    .d({scl_lk, sda_lk}), .q({scl_s, sda_s}));

  // Pins are only pulled low or released
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_n = ~scl_drv_lk;
  assign sda_oe_n = ~sda_drv_lk;

  // Line events seen in the system domain
  wire scl_rise = clk_en & scl_s & ~scl_d_reg;
  wire scl_fall = clk_en & ~scl_s & scl_d_reg;
  wire start_det = clk_en & scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire stop_det = clk_en & scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  wire tick = src_ovf[src_sel];
  wire low_done = ph_cnt >= smb_pkg::LOW_TICKS;
  wire high_done = ph_cnt >= smb_pkg::HIGH_TICKS;
  wire scl_high = scl_s & scl_d_reg;
  wire in_bit = state_reg == smb_pkg::SMB_LOW
    || state_reg == smb_pkg::SMB_HIGH;
  wire samp = scl_rise & in_bit;
  wire data_bit = bit_cnt_reg < smb_pkg::ACK_BIT;
  wire go = clk_en & sw_go & state_reg == smb_pkg::SMB_WAIT;
  wire bit_end = master_reg
    ? (state_reg == smb_pkg::SMB_HIGH && scl_high && high_done)
    : (state_reg == smb_pkg::SMB_HIGH && scl_fall);
  wire arb_evt = samp & master_reg & tx_reg & data_bit
    & shift_data_reg[7] & ~sda_s;
  wire fto_evt = clk_en & busy_reg & free_timeout_enable
    & free_cnt >= smb_pkg::FREE_TICKS;
  wire lto_evt = clk_en & low_timeout_enable & lt_cnt == LT_MAX;
  wire ph_clr = state_next != state_reg || scl_rise;

  // Phase timer counts overflow ticks of the selected source
  smb_tick_cnt #(.W(2), .MAX(smb_pkg::PHASE_CNT_MAX)) u_phase (
    .clock(clock), .sys_rst(sys_rst), .clk_en(clk_en),
    .clear(ph_clr), .tick(tick), .count(ph_cnt));
  // Bus-free timer runs as slave too and needs the tick source
  smb_tick_cnt #(.W(4), .MAX(smb_pkg::FREE_CNT_MAX)) u_free (
    .clock(clock), .sys_rst(sys_rst), .clk_en(clk_en),
    .clear(~(scl_s & sda_s) | ~free_timeout_enable),
    .tick(tick), .count(free_cnt));
  // SCL low timer in system cycles
  smb_tick_cnt #(.W(LTW), .MAX(LT_MAX)) u_low (
    .clock(clock), .sys_rst(sys_rst), .clk_en(clk_en),
    .clear(scl_s | ~low_timeout_enable | ~enable_iface),
    .tick(1'b1), .count(lt_cnt));

  // Next state of the byte engine
  always_comb
  begin
    state_next = state_reg;
    bit_next = bit_cnt_reg;
    shd_next = shift_data_reg;
    master_next = master_reg;
    tx_next = tx_reg;
    addr_next = addr_reg;
    rw_next = rw_reg;
    ack_rx_next = ack_rx_reg;
    stop_pend_next = stop_pend_reg;
    ack_send_next = go ? sw_ack_send : ack_send_reg;
    si_set = 1'b0;
    start_set = 1'b0;
    stop_set = 1'b0;
    if (clk_en && sw_data_load && !in_bit)
      shd_next = sw_data;
    unique case (state_reg)
      smb_pkg::SMB_IDLE:
        if (clk_en && start_pend_reg && !busy_reg)
        begin
          state_next = smb_pkg::SMB_START_C;
          master_next = 1'b1;
        end
      smb_pkg::SMB_START_A:
        if (low_done)
          state_next = smb_pkg::SMB_START_B;
      smb_pkg::SMB_START_B:
        if (scl_high && high_done)
          state_next = smb_pkg::SMB_START_C;
      smb_pkg::SMB_START_C:
        if (high_done)
        begin
          state_next = smb_pkg::SMB_WAIT;
          si_set = 1'b1;
          start_set = 1'b1;
          bit_next = 4'h0;
          tx_next = 1'b1;
          addr_next = 1'b1;
        end
      smb_pkg::SMB_LOW:
        if (master_reg ? low_done : scl_rise)
          state_next = smb_pkg::SMB_HIGH;
      smb_pkg::SMB_HIGH:
        if (bit_end && bit_cnt_reg == smb_pkg::LAST_BIT && !tx_reg)
        begin
          state_next = smb_pkg::SMB_WAIT;
          si_set = 1'b1;
          bit_next = smb_pkg::ACK_BIT;
        end
        else if (bit_end && bit_cnt_reg == smb_pkg::ACK_BIT)
        begin
          bit_next = 4'h0;
          addr_next = 1'b0;
          if (addr_reg)
            tx_next = master_reg ? ~rw_reg : rw_reg;
          if (tx_reg)
          begin
            state_next = smb_pkg::SMB_WAIT;
            si_set = 1'b1;
          end
          else if (addr_reg && !master_reg && !ack_rx_reg)
            state_next = smb_pkg::SMB_IDLE;
          else if (stop_pend_reg)
            state_next = smb_pkg::SMB_STOP_A;
          else
            state_next = smb_pkg::SMB_LOW;
        end
        else if (bit_end)
        begin
          bit_next = bit_cnt_reg + 4'h1;
          state_next = smb_pkg::SMB_LOW;
        end
      smb_pkg::SMB_WAIT:
        if (go && bit_cnt_reg == smb_pkg::ACK_BIT)
        begin
          state_next = smb_pkg::SMB_LOW;
          stop_pend_next = master_reg & sw_stop;
        end
        else if (go && master_reg && sw_stop)
          state_next = smb_pkg::SMB_STOP_A;
        else if (go && master_reg && sw_start)
          state_next = smb_pkg::SMB_START_A;
        else if (go && !master_reg && tx_reg && !ack_rx_reg)
          state_next = smb_pkg::SMB_IDLE;
        else if (go)
          state_next = smb_pkg::SMB_LOW;
      smb_pkg::SMB_STOP_A:
        if (low_done)
          state_next = smb_pkg::SMB_STOP_B;
      smb_pkg::SMB_STOP_B:
        if (scl_high && high_done)
          state_next = smb_pkg::SMB_STOP_C;
      smb_pkg::SMB_STOP_C:
        if (high_done)
        begin
          state_next = smb_pkg::SMB_IDLE;
          master_next = 1'b0;
          stop_pend_next = 1'b0;
        end
      default:
        state_next = smb_pkg::SMB_IDLE;
    endcase
    // Shift in bus bits, catch direction and acknowledge
    if (samp && data_bit)
    begin
      shd_next = {shift_data_reg[6:0], sda_s};
      if (addr_reg && bit_cnt_reg == smb_pkg::LAST_BIT)
        rw_next = sda_s;
    end
    else if (samp)
      ack_rx_next = ~sda_s;
    if (arb_evt)
    begin
      master_next = 1'b0;
      tx_next = 1'b0;
    end
    // Another master's START addresses us as slave
    if (start_det && !master_reg && enable_iface)
    begin
      state_next = smb_pkg::SMB_LOW;
      bit_next = 4'h0;
      tx_next = 1'b0;
      addr_next = 1'b1;
    end
    if ((stop_det && !master_reg && state_reg != smb_pkg::SMB_IDLE)
        || fto_evt)
    begin
      si_set = 1'b1;
      stop_set = 1'b1;
      if (!master_reg)
        state_next = smb_pkg::SMB_IDLE;
    end
    if (lto_evt || !enable_iface)
    begin
      state_next = smb_pkg::SMB_IDLE;
      master_next = 1'b0;
      stop_pend_next = 1'b0;
      bit_next = 4'h0;
    end
  end

  // Line drive decode, SDA bit and setup levels move only once SCL is seen low
  wire bit_val = bit_next < smb_pkg::ACK_BIT
    ? tx_next & ~shd_next[7]
    : ~tx_next & ack_send_next;
  wire line_low = ~scl_s;
  wire st_low = state_next == smb_pkg::SMB_LOW;
  wire st_stop_a = state_next == smb_pkg::SMB_STOP_A;
  wire st_start_a = state_next == smb_pkg::SMB_START_A;
  wire sda_force = state_next == smb_pkg::SMB_START_C
    || state_next == smb_pkg::SMB_STOP_B;
  wire sda_free = state_next == smb_pkg::SMB_IDLE
    || state_next == smb_pkg::SMB_STOP_C;
  assign sda_drv_next = sda_force ? 1'b1
    : sda_free ? 1'b0
    : (st_low && line_low) ? bit_val
    : (st_stop_a && line_low) ? 1'b1
    : (st_start_a && line_low) ? 1'b0
    : sda_drv_reg;
  assign scl_drv_next = enable_iface && !lto_evt
    && (state_next == smb_pkg::SMB_WAIT
      || (master_next && (st_low || st_stop_a || st_start_a)));

  // Pending START, bus busy and sticky flags; set beats clear for busy and flags, clear beats set for pending START
  assign start_pend_next = enable_iface & ~lto_evt
    & (start_pend_reg | (clk_en & sw_start & ~master_reg))
    & ~(state_next == smb_pkg::SMB_START_C
      && state_reg == smb_pkg::SMB_IDLE);
  assign busy_next = start_det | (busy_reg & ~stop_det & ~fto_evt);
  wire clr = clk_en & sw_go;

  // Byte engine registers
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      state_reg <= smb_pkg::SMB_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_data_reg <= smb_pkg::DATA_RST;
      {master_reg, tx_reg, addr_reg, rw_reg} <= 4'h0;
      {ack_send_reg, ack_rx_reg, stop_pend_reg} <= 3'h0;
    end
    else if (clk_en)
    begin
      state_reg <= state_next;
      bit_cnt_reg <= bit_next;
      shift_data_reg <= shd_next;
      {master_reg, tx_reg, addr_reg, rw_reg} <=
        {master_next, tx_next, addr_next, rw_next};
      {ack_send_reg, ack_rx_reg, stop_pend_reg} <=
        {ack_send_next, ack_rx_next, stop_pend_next};
    end
  end

  // Line drive, line history and status flags
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      {scl_drv_reg, sda_drv_reg, scl_d_reg, sda_d_reg} <= 4'h3;
      {start_pend_reg, busy_reg, reload_reg} <= 3'h0;
      {si_reg, start_reg, stop_reg, arb_reg, lto_reg} <= 5'h00;
    end
    else if (clk_en)
    begin
      {scl_drv_reg, sda_drv_reg} <= {scl_drv_next, sda_drv_next};
      {scl_d_reg, sda_d_reg} <= {scl_s, sda_s};
      start_pend_reg <= start_pend_next;
      busy_reg <= busy_next;
      reload_reg <= low_timeout_enable & scl_s;
      si_reg <= si_set | (si_reg & ~clr);
      start_reg <= start_set | (start_reg & ~clr);
      stop_reg <= stop_set | (stop_reg & ~clr);
      arb_reg <= arb_evt | (arb_reg & ~clr);
      lto_reg <= lto_evt | (lto_reg & ~clr);
    end
  end

  assign shift_data = shift_data_reg;
  assign byte_irq = si_reg;
  assign start_sent = start_reg;
  assign stop_seen = stop_reg;
  assign arb_lost = arb_reg;
  assign ack_received = ack_rx_reg;
  assign is_master = master_reg;
  assign is_tx = tx_reg;
  assign bus_busy = busy_reg;
  assign low_timeout = lto_reg;
  assign timer_reload = reload_reg;

  // Checks on the byte engine
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  sequence start_seq_s;
    state_reg == smb_pkg::SMB_START_C ##1 state_reg == smb_pkg::SMB_WAIT;
  endsequence
  sequence ack_end_s;
    bit_end && clk_en && bit_cnt_reg == smb_pkg::ACK_BIT && tx_reg
      && enable_iface && !lto_evt;
  endsequence

  slave_scl_a: assert property (
    (!master_reg && state_reg != smb_pkg::SMB_WAIT) |-> !scl_drv_reg)
    else $error("slave drove SCL outside stretch");
  free_gate_a: assert property (
    (state_reg == smb_pkg::SMB_START_C
      && $past(state_reg) == smb_pkg::SMB_IDLE) |-> !$past(busy_reg))
    else $error("master start while bus busy");
  arb_drop_a: assert property (
    (arb_evt && enable_iface && !lto_evt) |=> !master_reg && arb_reg)
    else $error("arbitration loss not handled");
  free_stop_a: assert property (
    fto_evt |=> stop_reg && si_reg && !busy_reg)
    else $error("free timeout did not act as stop");
  reload_hold_a: assert property (
    (clk_en && low_timeout_enable && scl_s) |=> timer_reload)
    else $error("timer not held in reload");
  low_reset_a: assert property (
    lto_evt |=> state_reg == smb_pkg::SMB_IDLE && !scl_drv_reg)
    else $error("low timeout did not reset");
  rx_flag_a: assert property (
    ($rose(si_reg) && !tx_reg && bit_cnt_reg == smb_pkg::ACK_BIT)
      |-> state_reg == smb_pkg::SMB_WAIT && !sda_drv_reg)
    else $error("receive flag not before acknowledge");
  tx_flag_a: assert property (
    ack_end_s |=> si_reg && state_reg == smb_pkg::SMB_WAIT)
    else $error("transmit flag not after acknowledge");
  start_flag_a: assert property (
    start_seq_s |-> si_reg && start_reg && master_reg)
    else $error("start not flagged");
endmodule : smb_iface
`default_nettype wire

// ==== smb_bus_model.sv ====
// Behavioural slave standing on the open-drain clock and data wires
`timescale 1ns/10ps
`default_nettype none
module smb_bus_model (
  input wire logic scl,
  input wire logic sda,
  input wire logic hold_low,
  input wire logic do_stretch,
  output logic scl_lo,
  output logic sda_lo,
  output logic [7:0] last_byte,
  output int n_start,
  output int n_stop
);
  logic stretch_lo;
  int nbit;
  // Only ever pulls low; released lines go to the pull-up
  assign scl_lo = stretch_lo | hold_low;
  // Idle state
  initial
  begin
    stretch_lo = 1'b0;
    sda_lo = 1'b0;
    last_byte = 8'h00;
    n_start = 0;
    n_stop = 0;
    nbit = 0;
  end
  // Start and stop: data edge while clock is high
  always @(negedge sda)
    if (scl === 1'b1 && $time > 0)
    begin
      n_start++;
      nbit = 0;
    end
  always @(posedge sda)
    if (scl === 1'b1 && $time > 0)
      n_stop++;
  // Shift in on clock rise, msb first
  always @(posedge scl)
    if ($time == 0)
      nbit = 0;
    else if (nbit < 8)
    begin
      last_byte = {last_byte[6:0], sda};
      nbit++;
    end
    else
      nbit = 0;
  // Ack through the ninth clock, then optional low stretch
  always @(negedge scl)
    if (nbit == 8)
      sda_lo <= 1'b1;
    else if (sda_lo)
    begin
      sda_lo <= 1'b0;
      if (do_stretch)
      begin
        stretch_lo = 1'b1;
        #2000 stretch_lo = 1'b0;
      end
    end
endmodule : smb_bus_model
`default_nettype wire

// ==== smb_iface_test.sv ====
// Self-checking bench of the two-wire bus controller
`timescale 1ns/10ps
`default_nettype none
module smb_iface_test;
  logic clock, link_clk, sys_rst, low_timeout_enable, free_timeout_enable;
  logic sw_start, sw_stop, sw_go, sw_data_load, tb_scl_lo, tb_sda_lo;
  logic hold_low, do_stretch, m_scl_lo, m_sda_lo, scl_w, sda_w;
  logic [7:0] sw_data, shift_data, last_byte;
  logic [3:0] src_ovf, tick_cnt;
  logic scl_oe_n, sda_oe_n, byte_irq, start_sent, stop_seen, arb_lost;
  logic ack_received, is_master, is_tx, bus_busy, low_timeout, timer_reload;
  int n_start, n_stop, n_fail, cmp_count, i;
  // Wired-and of all pull-downs with pull-up
  // Unknown enable before link reset counts as released
  assign scl_w = (scl_oe_n !== 1'b0) & ~m_scl_lo & ~tb_scl_lo;
  assign sda_w = (sda_oe_n !== 1'b0) & ~m_sda_lo & ~tb_sda_lo;
  assign src_ovf = (tick_cnt == 4'h0) ? 4'h2 : 4'h0;
  // Tick source: one overflow every 16 clocks
  always @(posedge clock)
    tick_cnt <= tick_cnt + 4'h1;
  // Clocks, link clock unrelated in phase
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  initial
  begin
    link_clk = 1'b0;
    #17;
    forever #62.5 link_clk = ~link_clk;
  end
  smb_iface #(.LOW_TIMEOUT_CYC(200)) u_dut (.clock, .sys_rst,
    .clk_en(1'b1), .link_clk, .scl_in(scl_w), .scl_out(), .scl_oe_n,
    .sda_in(sda_w), .sda_out(), .sda_oe_n, .enable_iface(1'b1),
    .low_timeout_enable, .free_timeout_enable, .src_sel(2'h1), .src_ovf,
    .sw_start, .sw_stop, .sw_go, .sw_ack_send(1'b1), .sw_data_load,
    .sw_data, .shift_data, .byte_irq, .start_sent, .stop_seen, .arb_lost,
    .ack_received, .is_master, .is_tx, .bus_busy, .low_timeout,
    .timer_reload);
  smb_bus_model u_far (.scl(scl_w), .sda(sda_w), .hold_low, .do_stretch,
    .scl_lo(m_scl_lo), .sda_lo(m_sda_lo), .last_byte, .n_start, .n_stop);
  task automatic check(input string what, input logic [7:0] seen, exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic check_bit(input string what, input logic seen, exp);
    check(what, {7'h00, seen}, {7'h00, exp});
  endtask : check_bit
  task automatic finish_test;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  task automatic cycles(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cycles
  task automatic do_reset;
    sys_rst = 1'b1;
    cycles(6);
    sys_rst = 1'b0;
  endtask : do_reset
  task automatic pulse_go(input logic stop);
    sw_go = 1'b1;
    sw_stop = stop;
    cycles(1);
    sw_go = 1'b0;
    sw_stop = 1'b0;
  endtask : pulse_go
  task automatic load_go(input logic [7:0] b);
    sw_data = b;
    sw_data_load = 1'b1;
    cycles(1);
    sw_data_load = 1'b0;
    pulse_go(1'b0);
  endtask : load_go
  task automatic wait_irq;
    for (int k = 0; k < 3000 && byte_irq !== 1'b1; k++)
      cycles(1);
  endtask : wait_irq
  task automatic t_reset_vals;
    cycles(4);
    check("shift_data", shift_data, 8'h00);
    check_bit("byte_irq", byte_irq, 1'b0);
    check_bit("scl_oe_n", scl_oe_n, 1'b1);
    check_bit("sda_oe_n", sda_oe_n, 1'b1);
  endtask : t_reset_vals
  task automatic t_master_write;
    sw_start = 1'b1;
    cycles(1);
    sw_start = 1'b0;
    wait_irq();
    check_bit("start_sent", start_sent, 1'b1);
    check_bit("is_master", is_master, 1'b1);
    check("starts", n_start[7:0], 8'h01);
    load_go(8'ha4);
    wait_irq();
    check("address", last_byte, 8'ha4);
    check_bit("addr_ack", ack_received, 1'b1);
    check_bit("is_tx", is_tx, 1'b1);
    do_stretch = 1'b1;
    load_go(8'h5c);
    wait_irq();
    check("data", last_byte, 8'h5c);
    check_bit("data_ack", ack_received, 1'b1);
    pulse_go(1'b1);
    for (i = 0; i < 3000 && n_stop == 0; i++)
      cycles(1);
    cycles(20);
    check("stops", n_stop[7:0], 8'h01);
    check_bit("bus_busy", bus_busy, 1'b0);
    check_bit("stop_seen", stop_seen, 1'b0);
    check_bit("arb_lost", arb_lost, 1'b0);
    do_stretch = 1'b0;
  endtask : t_master_write
  task automatic t_low_timeout;
    low_timeout_enable = 1'b1;
    cycles(10);
    check_bit("reload_high", timer_reload, 1'b1);
    hold_low = 1'b1;
    cycles(12);
    check_bit("reload_low", timer_reload, 1'b0);
    cycles(250);
    check_bit("low_timeout", low_timeout, 1'b1);
    hold_low = 1'b0;
    cycles(12);
    pulse_go(1'b0);
    cycles(2);
    check_bit("timeout_clr", low_timeout, 1'b0);
    low_timeout_enable = 1'b0;
  endtask : t_low_timeout
  task automatic t_free_timeout;
    free_timeout_enable = 1'b1;
    tb_sda_lo = 1'b1;
    cycles(10);
    tb_scl_lo = 1'b1;
    cycles(10);
    tb_sda_lo = 1'b0;
    cycles(10);
    tb_scl_lo = 1'b0;
    cycles(10);
    check_bit("busy_start", bus_busy, 1'b1);
    pulse_go(1'b0);
    sw_start = 1'b1;
    cycles(1);
    sw_start = 1'b0;
    cycles(40);
    check_bit("start_held", start_sent, 1'b0);
    for (i = 0; i < 1000 && stop_seen !== 1'b1; i++)
      cycles(1);
    check_bit("free_stop", stop_seen, 1'b1);
    check_bit("free_wait", i > 90, 1'b1);
    check_bit("free_irq", byte_irq, 1'b1);
    for (i = 0; i < 400 && start_sent !== 1'b1; i++)
      cycles(1);
    check_bit("start_after", start_sent, 1'b1);
    do_reset();
    free_timeout_enable = 1'b0;
  endtask : t_free_timeout
  // Main sequence
  initial
  begin
    {low_timeout_enable, free_timeout_enable, sw_start, sw_stop} = 4'h0;
    {sw_go, sw_data_load, tb_scl_lo, tb_sda_lo} = 4'h0;
    {hold_low, do_stretch} = 2'h0;
    sw_data = 8'h00;
    tick_cnt = 4'h0;
    n_fail = 0;
    cmp_count = 0;
    do_reset();
    t_reset_vals();
    t_master_write();
    t_low_timeout();
    t_free_timeout();
    finish_test();
  end
  // Watchdog against a hang
  initial
  begin
    #2000000;
    n_fail++;
    finish_test();
  end
endmodule : smb_iface_test
`default_nettype wire
